/* File: src/phy_status_regs.v */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "phy_status_defs.vh"

// Notes on behaviour
// (R1) Jabber shown only while at 10 Mb/s
// (R2) Jabber mirrored, not cleared by summary read
// (R3) Bit 4 shows negotiation done
// (R4) Bit 3 shows loopback enabled
// (R5) Bit 2 duplex, one is full
// (R6) Bit 1 speed, one is 10 Mb/s
// (R7) Software trusts duplex/speed only with link
// (R8) Bit 0 mirrors link, not cleared by read
// (R9) Counter upper byte ignores writes, reads zero
// (R10) False-carrier count increments per event
// (R11) False-carrier count sticks at maximum
// (R12) Counters read-only, cleared when read
// (R13) Receive error counts on carrier with bad symbol
// (R14) At most one count per carrier event
// (R15) No count when collision during carrier
// (R16) Receive error count sticks at maximum
// (R17) Receive error counter read clears bit 13
// (R18) False-carrier counter read clears bit 11
// (R19) Read returns old count; concurrent event kept
module phy_status_regs #(
    parameter CNT_W = 8,
    parameter ADDR_W = 12
) (
    input wire aclk, // 125 MHz clock
    input wire aresetn, // Synchronous reset
    input wire [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write strobes
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire link_up, // Valid link at either rate
    input wire speed10, // One at 10 Mb/s
    input wire full_duplex, // One for full duplex
    input wire loopback_on, // Loopback enabled
    input wire negotiation_done_flag, // Auto-negotiation complete
    input wire jabber_seen, // Jabber flag from basic link status word
    input wire false_carrier_evt, // One-cycle false carrier pulse
    input wire carrier_valid, // High for duration of a carrier event
    input wire invalid_symbol, // Invalid data symbol, pulse or level
    input wire collision, // Collision present
    output reg irq // Level interrupt
);

    // Summary status, latched flags and counter fields
    reg [15:0] summary_r;
    reg fc_latch_r;
    reg rxerr_latch_r;
    reg [CNT_W-1:0] false_carrier_count_field_r;
    reg [CNT_W-1:0] rx_error_count_field_r;
    // Carrier event, link change and interrupt tracking
    reg carrier_d_r;
    reg bad_sym_r;
    reg coll_r;
    reg link_d_r;
    reg [`IRQ_W-1:0] irq_stat_r;
    reg [`IRQ_W-1:0] irq_mask_r;
    // Bus holding state
    reg aw_held_r;
    reg w_held_r;
    reg [ADDR_W-1:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    // Next values of the registers above except carrier_d_r, link_d_r, awaddr_r, wdata_r and wstrb_r
    reg [15:0] summary_nxt;
    reg [CNT_W-1:0] false_carrier_count_field_nxt;
    reg [CNT_W-1:0] rx_error_count_field_nxt;
    reg fc_latch_nxt;
    reg rxerr_latch_nxt;
    reg bad_sym_nxt;
    reg coll_nxt;
    reg [`IRQ_W-1:0] irq_stat_nxt;
    reg [`IRQ_W-1:0] irq_mask_nxt;
    reg irq_nxt;
    reg [31:0] rdata_nxt;
    reg [1:0] rresp_nxt;
    reg awready_nxt;
    reg wready_nxt;
    reg bvalid_nxt;
    reg [1:0] bresp_nxt;
    reg aw_held_nxt;
    reg w_held_nxt;

    wire ar_fire = s_axi_arvalid & s_axi_arready;
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire [`IDX_W-1:0] rd_idx = reg_index(s_axi_araddr);
    wire [`IDX_W-1:0] wr_idx = reg_index(awaddr_r);
    wire rd_fc = ar_fire & (rd_idx == `IDX_FALSE_CARRIER);
    wire rd_rx = ar_fire & (rd_idx == `IDX_RX_ERROR);
    wire wr_ok = (wr_idx == `IDX_STATUS_SUMMARY) || (wr_idx == `IDX_FALSE_CARRIER) ||
                 (wr_idx == `IDX_RX_ERROR) || (wr_idx == `IDX_IRQ_STATUS) || (wr_idx == `IDX_IRQ_MASK);

    // Carrier event ends on the falling edge of carrier_valid
    wire carrier_end = carrier_d_r & ~carrier_valid;
    wire bad_now = bad_sym_r | (carrier_valid & invalid_symbol);
    wire coll_now = coll_r | (carrier_valid & collision);
    wire rxerr_evt = carrier_end & bad_sym_r & ~coll_r; // [R13] [R14] [R15]
    wire link_chg = link_d_r ^ link_up;
    // Interrupt sources share the status and mask layout
    wire [`IRQ_W-1:0] irq_evt = {link_chg, rxerr_evt, false_carrier_evt};
    wire irq_stat_wr = do_write & wstrb_r[0] & (wr_idx == `IDX_IRQ_STATUS);
    wire irq_mask_wr = do_write & wstrb_r[0] & (wr_idx == `IDX_IRQ_MASK);

    // Summary reads lag the status inputs by one cycle
    // Counter reads return the count held before the clearing edge
    // Receive errors count when the carrier drops, not at the bad symbol,
    // so a collision late in the same event can still veto the count

    // Word index of a byte address; low bits unused on an aligned bus
    function [`IDX_W-1:0] reg_index;
        input [ADDR_W-1:0] a;
        begin
            reg_index = a[`IDX_LSB +: `IDX_W];
        end
    endfunction

    // Clear-on-read saturating counter step
    function [CNT_W-1:0] cnt_step;
        input [CNT_W-1:0] cur;
        input evt;
        input clr;
        begin
            if (clr) begin
                cnt_step = evt ? `CNT_ONE : `CNT_ZERO; // [R12] [R19]
            end else if (evt && cur != `CNT_MAX) begin
                cnt_step = cur + `CNT_ONE; // [R10] [R11] [R16]
            end else begin
                cnt_step = cur;
            end
        end
    endfunction

    // Summary word assembled from live inputs; other bits out of scope read zero
    always @* begin
        summary_nxt = 16'h0000;
        summary_nxt[`SUM_LINK] = link_up; // [R8]
        summary_nxt[`SUM_SPEED10] = speed10; // [R6]
        summary_nxt[`SUM_DUPLEX] = full_duplex; // [R5]
        summary_nxt[`SUM_LOOPBACK] = loopback_on; // [R4]
        summary_nxt[`SUM_NEG_DONE] = negotiation_done_flag; // [R3]
        // Masked at 100 Mb/s where the flag has no meaning
        summary_nxt[`SUM_JABBER] = jabber_seen & speed10; // [R1] [R2]
    end

    // Registered so the read mux sees flops only
    always @(posedge aclk) begin
        if (!aresetn) begin
            summary_r <= 16'h0000;
        end else begin
            summary_r <= summary_nxt;
        end
    end

    // Counter next values; a clear with an event in one cycle leaves one count
    always @* begin
        false_carrier_count_field_nxt = cnt_step(false_carrier_count_field_r, false_carrier_evt, rd_fc);
        rx_error_count_field_nxt = cnt_step(rx_error_count_field_r, rxerr_evt, rd_rx);
    end

    // Set wins over the read clear so no event is lost
    always @* begin
        fc_latch_nxt = fc_latch_r;
        if (false_carrier_evt) begin
            fc_latch_nxt = 1'b1;
        end else if (rd_fc) begin
            fc_latch_nxt = 1'b0; // [R18]
        end
    end

    always @* begin
        rxerr_latch_nxt = rxerr_latch_r;
        if (rxerr_evt) begin
            rxerr_latch_nxt = 1'b1;
        end else if (rd_rx) begin
            rxerr_latch_nxt = 1'b0; // [R17]
        end
    end

    // Carrier flags only accumulate inside one carrier event
    always @* begin
        bad_sym_nxt = 1'b0;
        coll_nxt = 1'b0;
        if (carrier_valid) begin
            bad_sym_nxt = bad_now; // [R13]
            coll_nxt = coll_now; // [R15]
        end
    end

    // Counters, their latched flags and carrier event tracking
    always @(posedge aclk) begin
        if (!aresetn) begin
            false_carrier_count_field_r <= `CNT_ZERO;
            rx_error_count_field_r <= `CNT_ZERO;
            fc_latch_r <= 1'b0;
            rxerr_latch_r <= 1'b0;
            carrier_d_r <= 1'b0;
            bad_sym_r <= 1'b0;
            coll_r <= 1'b0;
        end else begin
            false_carrier_count_field_r <= false_carrier_count_field_nxt;
            rx_error_count_field_r <= rx_error_count_field_nxt;
            fc_latch_r <= fc_latch_nxt;
            rxerr_latch_r <= rxerr_latch_nxt;
            carrier_d_r <= carrier_valid;
            bad_sym_r <= bad_sym_nxt;
            coll_r <= coll_nxt;
        end
    end

    // Interrupt status, write one to clear, set wins
    always @* begin
        irq_stat_nxt = irq_stat_r | irq_evt;
        if (irq_stat_wr) begin
            irq_stat_nxt = (irq_stat_r & ~wdata_r[`IRQ_W-1:0]) | irq_evt;
        end
        irq_mask_nxt = irq_mask_r;
        if (irq_mask_wr) begin
            irq_mask_nxt = wdata_r[`IRQ_W-1:0];
        end
        // Level output follows status by one cycle
        irq_nxt = |(irq_stat_r & irq_mask_r);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= {`IRQ_W{1'b0}};
            irq_mask_r <= {`IRQ_W{1'b0}};
            link_d_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            link_d_r <= link_up;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq <= irq_nxt;
        end
    end

    // Write channels: address and data taken in either order
    always @* begin
        awready_nxt = s_axi_awready;
        wready_nxt = s_axi_wready;
        bvalid_nxt = s_axi_bvalid;
        bresp_nxt = s_axi_bresp;
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        if (aw_fire) begin
            aw_held_nxt = 1'b1;
            awready_nxt = 1'b0;
        end
        if (w_fire) begin
            w_held_nxt = 1'b1;
            wready_nxt = 1'b0;
        end
        // Writes to the summary and counters are accepted and dropped
        if (do_write) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_ok ? `RESP_OKAY : `RESP_SLVERR; // [R9]
        end
        // One write at a time: both channels reopen after the response
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            awready_nxt = 1'b1;
            wready_nxt = 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= {ADDR_W{1'b0}};
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            s_axi_awready <= awready_nxt;
            s_axi_wready <= wready_nxt;
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp <= bresp_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            if (aw_fire) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    // Read word for the addressed register; unmapped reads answer an error
    always @* begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = `RESP_OKAY;
        if (rd_idx == `IDX_STATUS_SUMMARY) begin
            rdata_nxt[15:0] = summary_r | ({15'h0000, fc_latch_r} << `SUM_FC_LATCH) |
                              ({15'h0000, rxerr_latch_r} << `SUM_RXERR_LATCH);
        end else if (rd_idx == `IDX_FALSE_CARRIER) begin
            rdata_nxt[CNT_W-1:0] = false_carrier_count_field_r; // [R9] [R19]
        end else if (rd_idx == `IDX_RX_ERROR) begin
            rdata_nxt[CNT_W-1:0] = rx_error_count_field_r; // [R9] [R19]
        end else if (rd_idx == `IDX_IRQ_STATUS) begin
            rdata_nxt[`IRQ_W-1:0] = irq_stat_r;
        end else if (rd_idx == `IDX_IRQ_MASK) begin
            rdata_nxt[`IRQ_W-1:0] = irq_mask_r;
        end else begin
            rresp_nxt = `RESP_SLVERR;
        end
    end

    // Read channel; data sampled at the address edge so a clear returns the old count
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (ar_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rresp_nxt;
                s_axi_rdata <= rdata_nxt;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

/* File: src/phy_status_defs.vh */
`ifndef PHY_STATUS_DEFS_VH
`define PHY_STATUS_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_STATUS_SUMMARY 8'h10
`define IDX_FALSE_CARRIER 8'h14
`define IDX_RX_ERROR 8'h15
`define IDX_IRQ_STATUS 8'h18
`define IDX_IRQ_MASK 8'h19
`define IDX_LSB 2
`define IDX_W 8

// Summary word bit positions
`define SUM_LINK 0
`define SUM_SPEED10 1
`define SUM_DUPLEX 2
`define SUM_LOOPBACK 3
`define SUM_NEG_DONE 4
`define SUM_JABBER 5
`define SUM_FC_LATCH 11
`define SUM_RXERR_LATCH 13

// Interrupt status / mask bit positions
`define IRQ_FC 0
`define IRQ_RXERR 1
`define IRQ_LINK 2
`define IRQ_W 3

`define CNT_MAX 8'hff
`define CNT_ONE 8'h01
`define CNT_ZERO 8'h00

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: bench/phy_status_regs_chk.sv */
`timescale 1ns/100ps
module phy_status_regs_chk #(parameter ADDR_W = 12) (
    input wire aclk, aresetn, s_axi_arvalid, s_axi_arready, s_axi_rvalid, // Clock, reset, read
    input wire [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire [31:0] s_axi_rdata, // Read data
    input wire [1:0] s_axi_rresp, // Read response
    input wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, // Write
    input wire link_up, speed10, full_duplex, loopback_on, negotiation_done_flag, jabber_seen, // Status
    input wire false_carrier_evt, carrier_valid, invalid_symbol, collision // Events
);
    reg [ADDR_W-1:0] ra;
    reg [7:0] fcm, rxm, fx, rx;
    reg cvd, bad, col;
    wire rhs = s_axi_arvalid && s_axi_arready;
    wire fcr = rhs && s_axi_araddr == 12'h050;
    wire rxr = rhs && s_axi_araddr == 12'h054;
    wire rxe = cvd && !carrier_valid && bad && !col;
    wire [5:0] st = {jabber_seen & speed10, negotiation_done_flag, loopback_on, full_duplex, speed10, link_up};
    // Reference counts, judged only at reads
    always @(posedge aclk) begin
        if (!aresetn) begin
            {ra, fcm, rxm, fx, rx, cvd, bad, col} <= 0;
        end else begin
            cvd <= carrier_valid;
            bad <= carrier_valid & (bad | invalid_symbol);
            col <= carrier_valid & (col | collision);
            if (rhs) ra <= s_axi_araddr;
            if (fcr) fx <= fcm;
            if (rxr) rx <= rxm;
            fcm <= fcr ? {7'h0, false_carrier_evt} : fcm + {7'h0, false_carrier_evt && fcm != 8'hff};
            rxm <= rxr ? {7'h0, rxe} : rxm + {7'h0, rxe && rxm != 8'hff};
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_sum;
        $rose(s_axi_rvalid) && ra == 12'h040 && $past(st) == st && $past(st, 2) == st |-> s_axi_rdata[5:0] == st;
    endproperty
    a_sum: assert property (p_sum) else $error("summary bits wrong");
    property p_hi;
        s_axi_rvalid && (ra == 12'h050 || ra == 12'h054) |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_hi: assert property (p_hi) else $error("counter upper bits set");
    property p_fc;
        $rose(s_axi_rvalid) && ra == 12'h050 |-> s_axi_rdata[7:0] == fx;
    endproperty
    a_fc: assert property (p_fc) else $error("false carrier count wrong");
    property p_rx;
        $rose(s_axi_rvalid) && ra == 12'h054 |-> s_axi_rdata[7:0] == rx;
    endproperty
    a_rx: assert property (p_rx) else $error("receive error count wrong");
    property p_fcl;
        $rose(s_axi_rvalid) && ra == 12'h040 && $past(fcm) == $past(fcm, 2) |-> s_axi_rdata[11] == ($past(fcm) != 8'h0);
    endproperty
    a_fcl: assert property (p_fcl) else $error("false carrier latch wrong");
    property p_rxl;
        $rose(s_axi_rvalid) && ra == 12'h040 && $past(rxm) == $past(rxm, 2) |-> s_axi_rdata[13] == ($past(rxm) != 8'h0);
    endproperty
    a_rxl: assert property (p_rxl) else $error("receive error latch wrong");
    property p_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_unm;
        $rose(s_axi_rvalid) && ra == 12'h07c |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not refused");
    c_fcmax: cover property ($rose(s_axi_rvalid) && ra == 12'h050 && s_axi_rdata[7:0] == 8'hff);
    c_rxmax: cover property ($rose(s_axi_rvalid) && ra == 12'h054 && s_axi_rdata[7:0] == 8'hff);
    c_unm: cover property ($rose(s_axi_rvalid) && ra == 12'h07c);
endmodule

bind phy_status_regs phy_status_regs_chk #(.ADDR_W(ADDR_W)) u_phy_status_regs_chk (.*);

/* File: bench/axi_lite_host.sv */
`timescale 1ns/100ps
module axi_lite_host (
    input wire aclk, // Clock
    output reg [11:0] s_axi_awaddr, s_axi_araddr, // Addresses
    output reg [31:0] s_axi_wdata, // Write data
    output reg [3:0] s_axi_wstrb, // Strobes
    output reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, // Requests
    input wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, // Answers
    input wire [1:0] s_axi_bresp, s_axi_rresp, // Responses
    input wire [31:0] s_axi_rdata // Read data
);
    initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = 0;
    initial {s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    task wr(input [11:0] a, input [31:0] d, output [1:0] r);
        reg aw, w;
        begin
            @(posedge aclk);
            {aw, w} = 2'h3;
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hf;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            while (aw || w) begin
                @(posedge aclk);
                if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 1'h0; s_axi_awaddr <= ~a; end
                if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 1'h0; s_axi_wdata <= ~d; end
            end
            while (!s_axi_bvalid) @(posedge aclk);
            r = s_axi_bresp;
            s_axi_bready <= 1'h0;
        end
    endtask
    task rd(input [11:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            @(posedge aclk);
            while (!s_axi_arready) @(posedge aclk);
            s_axi_arvalid <= 1'h0;
            s_axi_araddr <= ~a;
            while (!s_axi_rvalid) @(posedge aclk);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'h0;
        end
    endtask
endmodule

/* File: bench/phy_status_regs_bench.sv */
`timescale 1ns/100ps
module phy_status_regs_bench;
    reg aclk = 1'h0, aresetn = 1'h0, link_up = 1'h0, speed10 = 1'h0, full_duplex = 1'h0, loopback_on = 1'h0;
    reg negotiation_done_flag = 1'h0, jabber_seen = 1'h0, false_carrier_evt = 1'h0;
    reg carrier_valid = 1'h0, invalid_symbol = 1'h0, collision = 1'h0;
    wire [11:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0] s_axi_wstrb;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, irq;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    reg [31:0] d;
    reg [1:0] r;
    integer failures = 0, tests_run = 0, i;
    phy_status_regs u_phy_status_regs (.*);
    axi_lite_host u_host (.*);
    always #4 aclk = ~aclk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task rd(input [11:0] a); u_host.rd(a, d, r); endtask
    task wr(input [11:0] a, input [31:0] v); u_host.wr(a, v, r); endtask
    task pulse(input integer n);
        begin @(posedge aclk); false_carrier_evt <= 1'h1; repeat (n) @(posedge aclk); false_carrier_evt <= 1'h0; end
    endtask
    // Four-cycle carrier; second bad symbol must not count twice
    task carrier(input integer nbad, input c);
        begin
            @(posedge aclk); {carrier_valid, collision} <= {1'h1, c};
            @(posedge aclk); invalid_symbol <= nbad > 0;
            @(posedge aclk); invalid_symbol <= 1'h0;
            @(posedge aclk); invalid_symbol <= nbad > 1;
            @(posedge aclk); {carrier_valid, collision, invalid_symbol} <= 3'h0;
            @(posedge aclk);
        end
    endtask
    task t_status;
        reg [5:0] v;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                v = i < 6 ? (6'h01 << i) | 6'h01 : (i == 6 ? 6'h23 : 6'h3f); // Link held up
                @(posedge aclk);
                {jabber_seen, negotiation_done_flag, loopback_on, full_duplex, speed10, link_up} <= v;
                repeat (3) @(posedge aclk);
                v[5] = v[5] & v[1];
                rd(12'h040);
                chk(d, {26'h0, v});
                rd(12'h040);
                chk(d, {26'h0, v});
            end
            $display("status test done");
        end
    endtask
    task t_fc;
        begin
            pulse(3);
            wr(12'h050, 32'hffff_ffff);
            chk(r, 2'h0);
            rd(12'h040);
            chk(d[11], 1'h1);
            rd(12'h050);
            chk(d, 32'h3);
            rd(12'h050);
            chk(d, 32'h0);
            rd(12'h040);
            chk(d[11], 1'h0);
            pulse(300);
            rd(12'h050);
            chk(d, 32'hff);
            pulse(2);
            fork rd(12'h050); pulse(1); join
            chk(d, 32'h2);
            rd(12'h050);
            chk(d, 32'h1);
            $display("false carrier test done");
        end
    endtask
    task t_rx;
        begin
            carrier(1, 0); carrier(0, 0); carrier(2, 0); carrier(1, 1);
            rd(12'h040);
            chk(d[13], 1'h1);
            wr(12'h054, 32'hffff_ffff);
            rd(12'h054);
            chk(d, 32'h2);
            rd(12'h040);
            chk(d[13], 1'h0);
            for (i = 0; i < 260; i = i + 1) carrier(1, 0);
            rd(12'h054);
            chk(d, 32'hff);
            $display("receive error test done");
        end
    endtask
    task t_irq;
        begin
            wr(12'h060, 32'h7); wr(12'h064, 32'h1); pulse(1); repeat (3) @(posedge aclk);
            chk(irq, 1'h1);
            wr(12'h060, 32'h1); repeat (3) @(posedge aclk);
            chk(irq, 1'h0);
            wr(12'h064, 32'h0); pulse(1); repeat (3) @(posedge aclk);
            chk(irq, 1'h0);
            rd(12'h060);
            chk(d, 32'h1);
            link_up <= 1'h0;
            repeat (3) @(posedge aclk);
            rd(12'h060);
            chk(d, 32'h5);
            rd(12'h07c);
            chk({r, d}, 34'h2_0000_0000);
            wr(12'h07c, 32'h1);
            chk(r, 2'h2);
            $display("interrupt and map test done");
        end
    endtask
    task finish_test;
        begin
            $display("tests_run=%0d failures=%0d", tests_run, failures);
            if (failures == 0 && tests_run > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        t_status; t_fc; t_rx; t_irq;
        finish_test;
    end
    // Run needs about 2100 cycles
    initial begin #200000; failures = failures + 1; finish_test; end
endmodule
